// ==== hw/slwp_pkg.sv ====
// Shared constants for the serial latch write port
package slwp_pkg;
  // ==================== Clock and timing
  localparam int unsigned SYS_CLK_NS    = 20;  // System clock period
  localparam int unsigned SCLK_HALF_NS  = 80;  // Serial clock half period
  localparam int unsigned BYTE_GAP_NS   = 40;  // Idle gap between bytes
  localparam int unsigned LATCH_HOLD_NS = 80;  // Strobe high time
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned BYTE_GAP_CYC  = (BYTE_GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned LATCH_CYC     = (LATCH_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned CNT_W         = 4;   // Host wait counter width

  // ==================== Word layout
  localparam int unsigned WORD_W     = 32;     // Bits per latch word
  localparam int unsigned BYTE_W     = 8;      // Bits per host transfer
  localparam int unsigned SEL_W      = 3;      // Latch select field width
  localparam int unsigned SEL_LSB    = 0;      // Latch select position
  localparam int unsigned MOD_LSB    = 3;      // Modulus field position
  localparam int unsigned PHASE_LSB  = 15;     // Phase word position
  localparam int unsigned FIELD_W    = 12;     // Modulus and phase width
  localparam int unsigned TURN_W     = 16;     // Output phase, fraction of turn
  localparam int unsigned DIV_STEPS  = FIELD_W + TURN_W;
  localparam logic [SEL_W-1:0]   SEL_PHASE = 3'h1;    // Latch holding phase
  localparam logic [FIELD_W-1:0] MOD_MIN   = 12'h002; // Least legal modulus
  localparam logic [FIELD_W-1:0] MOD_RST   = 12'h002; // Modulus after reset
  localparam logic [FIELD_W-1:0] PHASE_RST = 12'h000; // Phase after reset
endpackage

// ==== hw/slwp_link_if.sv ====
// Three-wire link between host and synthesizer port
`timescale 1ns/1ps
`default_nettype none
interface slwp_link_if;
  logic serial_clk;    // Serial clock, host made
  logic serial_data;   // Serial data, host to device
  logic latch_strobe;  // Latch strobe, host driven

  // ==================== Views
  modport host   (output serial_clk, output serial_data, output latch_strobe);
  modport device (input serial_clk, input serial_data, input latch_strobe);
endinterface
`default_nettype wire

// ==== hw/slwp_device.sv ====
// Device end: write-only shift register, latches and phase word
`timescale 1ns/1ps
`default_nettype none
module slwp_device
  import slwp_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                reset_i,
  // Link
  slwp_link_if.device              link,
  // Latch writes
  output logic                     latch_wr_o,
  output logic [SEL_W-1:0]         latch_sel_o,
  output logic [WORD_W-1:0]        latch_data_o,
  // Output phase
  output logic [TURN_W-1:0]        phase_turn_o,
  output logic                     phase_valid_o
);
  // ==================== State
  typedef struct packed {
    logic [2:0]          sclk;     // [0] first, [1] second, [2] previous
    logic [1:0]          sdat;     // [0] first, [1] second
    logic [2:0]          strb;     // [0] first, [1] second, [2] previous
    logic [WORD_W-1:0]   shift;    // Input shift register
    logic                wr;       // Latch write pulse
    logic [SEL_W-1:0]    sel;      // Latch written
    logic [WORD_W-1:0]   data;     // Word written
    logic [FIELD_W-1:0]  phase;    // Phase word
    logic [FIELD_W-1:0]  modulus;  // Fractional modulus
    logic                busy;     // Divider running
    logic [4:0]          steps;    // Divider steps left
    logic [FIELD_W-1:0]  rem;      // Partial remainder
    logic [DIV_STEPS-1:0] num;     // Dividend being shifted out
    logic [TURN_W-1:0]   quo;      // Quotient bits
    logic [TURN_W-1:0]   turn;     // Output phase
    logic                valid;    // Output phase is current
  } slwp_dev_s;

  slwp_dev_s st;       // Registered state
  slwp_dev_s next_st;  // Next state

  // ==================== Next state
  always_comb begin
    logic [FIELD_W:0] trial;  // Remainder with next dividend bit
    trial   = '0;
    next_st = st;
    next_st.wr = 1'b0;
    // Two-flop synchronisers, third flop for edge detection
    next_st.sclk = {st.sclk[1], st.sclk[0], link.serial_clk};
    next_st.sdat = {st.sdat[0], link.serial_data};
    next_st.strb = {st.strb[1], st.strb[0], link.latch_strobe};
    // Shift on clock rise; last 32 bits always kept
    if (st.sclk[1] && !st.sclk[2]) begin
      next_st.shift = {st.shift[WORD_W-2:0], st.sdat[1]};
    end
    // Strobe rise moves the word to its latch
    if (st.strb[1] && !st.strb[2]) begin
      next_st.wr   = 1'b1;
      next_st.sel  = st.shift[SEL_LSB +: SEL_W];
      next_st.data = st.shift;
      if (st.shift[SEL_LSB +: SEL_W] == SEL_PHASE) begin
        next_st.phase   = st.shift[PHASE_LSB +: FIELD_W];
        next_st.modulus = st.shift[MOD_LSB +: FIELD_W];
        next_st.valid   = 1'b0;
      end
    end
    // Start division after a phase latch write
    if (st.wr && st.sel == SEL_PHASE && st.modulus != '0) begin
      next_st.busy  = 1'b1;
      next_st.steps = 5'(DIV_STEPS);
      next_st.rem   = '0;
      next_st.num   = {st.phase, {TURN_W{1'b0}}};
    end else if (st.busy) begin
      // Restoring division: turn = phase * 2^16 / modulus
      trial = {st.rem, st.num[DIV_STEPS-1]};
      if (trial >= {1'b0, st.modulus}) begin
        next_st.rem = FIELD_W'(trial - {1'b0, st.modulus});
        next_st.quo = {st.quo[TURN_W-2:0], 1'b1};
      end else begin
        next_st.rem = trial[FIELD_W-1:0];
        next_st.quo = {st.quo[TURN_W-2:0], 1'b0};
      end
      next_st.num   = {st.num[DIV_STEPS-2:0], 1'b0};
      next_st.steps = st.steps - 5'h01;
      if (st.steps == 5'h01) begin
        next_st.busy  = 1'b0;
        next_st.valid = 1'b1;
        // Phase equal to modulus wraps to zero, a full turn
        next_st.turn  = next_st.quo;
      end
    end
  end

  // ==================== Registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st         <= '0;
      st.phase   <= PHASE_RST;
      st.modulus <= MOD_RST;
      st.valid   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==================== Outputs
  // No path back to the link: the port is write-only
  assign latch_wr_o    = st.wr;
  assign latch_sel_o   = st.sel;
  assign latch_data_o  = st.data;
  assign phase_turn_o  = st.turn;
  assign phase_valid_o = st.valid;
endmodule
`default_nettype wire

// ==== hw/slwp_host.sv ====
// Host end: sends 32-bit latch words as four bytes over the link
`timescale 1ns/1ps
`default_nettype none
module slwp_host
  import slwp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  // Word request
  input  wire logic              cmd_valid_i,
  input  wire logic [WORD_W-1:0] cmd_word_i,
  output logic                   cmd_ready_o,
  // Result
  output logic                   cmd_done_o,
  output logic                   cmd_error_o,
  // Link
  slwp_link_if.host              link
);
  // ==================== Types
  typedef enum logic [2:0] {
    SLWP_IDLE,   // Waiting for a word
    SLWP_LOW,    // Clock low, data set up
    SLWP_HIGH,   // Clock high, device samples
    SLWP_GAP,    // Pause between bytes
    SLWP_TAIL,   // Clock low after last bit
    SLWP_LATCH   // Strobe high
  } slwp_host_e;

  typedef struct packed {
    slwp_host_e         state;   // Sequencer state
    logic [CNT_W-1:0]   cnt;     // Wait counter
    logic [4:0]         bits;    // Bits sent in this word
    logic [WORD_W-1:0]  shift;   // Word being sent, MSB first
    logic               sclk;    // Serial clock level
    logic               sdat;    // Serial data level
    logic               strobe;  // Latch strobe level
    logic               ready;   // Can take a word
    logic               done;    // Word latched pulse
    logic               error;   // Word refused pulse
  } slwp_host_s;

  slwp_host_s st;       // Registered state
  slwp_host_s next_st;  // Next state

  // ==================== Helpers
  logic half_up;  // Half clock period elapsed
  logic gap_up;   // Byte gap elapsed
  logic hold_up;  // Strobe hold elapsed
  logic bad_mod;  // Request carries an illegal modulus

  assign half_up = (st.cnt == CNT_W'(SCLK_HALF_CYC - 1));
  assign gap_up  = (st.cnt == CNT_W'(BYTE_GAP_CYC - 1));
  assign hold_up = (st.cnt == CNT_W'(LATCH_CYC - 1));
  // Only the phase latch carries a modulus
  assign bad_mod = (cmd_word_i[SEL_LSB +: SEL_W] == SEL_PHASE)
                && (cmd_word_i[MOD_LSB +: FIELD_W] < MOD_MIN);

  // ==================== Sequencer
  // The link clock is divided from the system clock,
  // so it only runs while a word is in flight
  always_comb begin
    next_st       = st;
    next_st.done  = 1'b0;
    next_st.error = 1'b0;
    next_st.cnt   = st.cnt + CNT_W'(1);
    case (st.state)
      SLWP_IDLE: begin
        next_st.cnt    = '0;
        next_st.sclk   = 1'b0;
        // Strobe idles low, so it is low before any clocking
        next_st.strobe = 1'b0;
        if (cmd_valid_i && st.ready) begin
          if (bad_mod) begin
            // Refused word never reaches the link
            next_st.error = 1'b1;
          end else begin
            next_st.ready = 1'b0;
            next_st.shift = cmd_word_i;
            next_st.bits  = '0;
            // First bit set up a half period ahead of the rise
            next_st.sdat  = cmd_word_i[WORD_W-1];
            next_st.state = SLWP_LOW;
          end
        end
      end
      SLWP_LOW: begin
        // Data held steady while the clock is low
        if (half_up) begin
          next_st.cnt   = '0;
          next_st.sclk  = 1'b1;
          next_st.state = SLWP_HIGH;
        end
      end
      SLWP_HIGH: begin
        if (half_up) begin
          next_st.cnt   = '0;
          // Falling edge: data may change now, away from the rise
          next_st.sclk  = 1'b0;
          next_st.shift = {st.shift[WORD_W-2:0], 1'b0};
          next_st.sdat  = st.shift[WORD_W-2];
          next_st.bits  = st.bits + 5'h01;
          if (st.bits == 5'(WORD_W - 1)) begin
            // All four bytes out: full word delivered
            next_st.state = SLWP_TAIL;
          end else if (st.bits[2:0] == 3'(BYTE_W - 1)) begin
            // Byte boundary, strobe stays low across it
            next_st.state = SLWP_GAP;
          end else begin
            next_st.state = SLWP_LOW;
          end
        end
      end
      SLWP_GAP: begin
        // Short pause, as between separate byte transfers
        if (gap_up) begin
          next_st.cnt   = '0;
          next_st.state = SLWP_LOW;
        end
      end
      SLWP_TAIL: begin
        // Wait so the last rise is seen before the strobe
        if (half_up) begin
          next_st.cnt    = '0;
          next_st.strobe = 1'b1;
          next_st.state  = SLWP_LATCH;
        end
      end
      SLWP_LATCH: begin
        // Strobe held high long enough to be sampled
        if (hold_up) begin
          next_st.cnt    = '0;
          next_st.strobe = 1'b0;
          next_st.done   = 1'b1;
          next_st.ready  = 1'b1;
          next_st.state  = SLWP_IDLE;
        end
      end
      default: begin
        // Lost state: park with the link quiet
        next_st        = st;
        next_st.state  = SLWP_IDLE;
        next_st.cnt    = '0;
        next_st.sclk   = 1'b0;
        next_st.strobe = 1'b0;
        next_st.ready  = 1'b1;
        next_st.done   = 1'b0;
        next_st.error  = 1'b0;
      end
    endcase
  end

  // ==================== Registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st       <= '0;
      st.state <= SLWP_IDLE;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==================== Outputs
  // All straight from flops; link lines never glitch
  assign cmd_ready_o       = st.ready;
  assign cmd_done_o        = st.done;
  assign cmd_error_o       = st.error;
  assign link.serial_clk   = st.sclk;
  assign link.serial_data  = st.sdat;
  assign link.latch_strobe = st.strobe;
endmodule
`default_nettype wire

// ==== sim/slwp_link_monitor.sv ====
// Wire checker for the three-wire latch link between host and device
`timescale 1ns/1ps
`default_nettype none
module slwp_link_monitor (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Link lines
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_strobe
);
  // ==================== Helpers
  logic       clk_q;     // Serial clock one cycle back
  logic [5:0] rise_cnt;  // Serial clock rises in the current word

  // Count restarts on each strobe, so a stray clock shows as a wrong count
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      clk_q    <= 1'b0;
      rise_cnt <= 6'h00;
    end else begin
      clk_q <= serial_clk;
      if (latch_strobe) begin
        rise_cnt <= 6'h00;
      end else if (serial_clk && !clk_q) begin
        rise_cnt <= rise_cnt + 6'h01;
      end
    end
  end

  // ==================== Properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_clk_high;
    serial_clk [*4] ##1 !serial_clk;
  endsequence
  sequence s_strobe_pulse;
    latch_strobe [*4] ##1 !latch_strobe;
  endsequence

  property p_data_still;
    !$stable(serial_data) |-> !serial_clk;
  endproperty
  property p_clk_high;
    $rose(serial_clk) |-> s_clk_high;
  endproperty
  property p_clk_low;
    $fell(serial_clk) |-> !serial_clk [*4];
  endproperty
  property p_byte_gap;
    $fell(serial_clk) && (rise_cnt == 6'h08 || rise_cnt == 6'h10 || rise_cnt == 6'h18) |-> !serial_clk [*6];
  endproperty
  property p_strobe_low_clk;
    serial_clk |-> !latch_strobe;
  endproperty
  property p_strobe_pulse;
    $rose(latch_strobe) |-> s_strobe_pulse;
  endproperty
  property p_word_count;
    $rose(latch_strobe) |-> rise_cnt == 6'h20;
  endproperty
  property p_strobe_after_clk;
    $rose(latch_strobe) |-> $past(serial_clk, 5) && !$past(serial_clk, 4) && !serial_clk;
  endproperty

  a_data_still : assert property (p_data_still) else $error("Data moved while clock high");
  a_clk_high : assert property (p_clk_high) else $error("Clock high time wrong");
  a_clk_low : assert property (p_clk_low) else $error("Clock low time short");
  a_byte_gap : assert property (p_byte_gap) else $error("Byte gap missing");
  a_strobe_low_clk : assert property (p_strobe_low_clk) else $error("Strobe high while clocking");
  a_strobe_pulse : assert property (p_strobe_pulse) else $error("Strobe pulse width wrong");
  a_word_count : assert property (p_word_count) else $error("Word not 32 clocks");
  a_strobe_after_clk : assert property (p_strobe_after_clk) else $error("Strobe not after last clock");
endmodule
`default_nettype wire

// ==== sim/tb_serial_latch_write_port.sv ====
// Testbench: host and device joined, plus a device fed by a rule-breaking driver
`timescale 1ns/1ps
`default_nettype none
module tb_serial_latch_write_port
  import slwp_pkg::*;
;
  // ==================== Signals
  logic              clk_sys_i = 1'b0;  // System clock
  logic              reset_i = 1'b1;    // Reset, high at start
  logic              cmd_valid_i = 1'b0;
  logic [WORD_W-1:0] cmd_word_i = '0;
  logic              cmd_ready_o, cmd_done_o, cmd_error_o;
  logic              latch_wr_o, phase_valid_o, f_wr;
  logic [SEL_W-1:0]  latch_sel_o, f_sel;
  logic [WORD_W-1:0] latch_data_o, f_data, wire_word;
  logic [TURN_W-1:0] phase_turn_o;
  int                errors = 0, total_checks = 0, strobe_cnt = 0;
  int                wr_cnt = 0, f_wr_cnt = 0;  // Latch write pulses seen on each device
  // Take to done: 32 bits of two halves, three byte gaps, tail and strobe hold
  localparam int     DONE_CYC = WORD_W * 2 * SCLK_HALF_CYC + (WORD_W / BYTE_W - 1) * BYTE_GAP_CYC
                              + SCLK_HALF_CYC + LATCH_CYC;
  int                mods[6] = '{2, 3, 100, 4095, 4095, 7};
  int                phs[6] = '{1, 1, 25, 4095, 1, 6};

  always #10 clk_sys_i = ~clk_sys_i;

  // ==================== Design and checker
  slwp_link_if link();
  slwp_link_if link_f();  // Second link, driven by the bench
  slwp_host i_slwp_host (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
    .cmd_word_i(cmd_word_i), .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o), .cmd_error_o(cmd_error_o),
    .link(link));
  slwp_device i_slwp_device (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(link), .latch_wr_o(latch_wr_o),
    .latch_sel_o(latch_sel_o), .latch_data_o(latch_data_o), .phase_turn_o(phase_turn_o),
    .phase_valid_o(phase_valid_o));
  slwp_device i_slwp_device_f (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(link_f), .latch_wr_o(f_wr),
    .latch_sel_o(f_sel), .latch_data_o(f_data), .phase_turn_o(), .phase_valid_o());
  slwp_link_monitor i_slwp_link_monitor (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .serial_clk(link.serial_clk), .serial_data(link.serial_data), .latch_strobe(link.latch_strobe));

  // Wire sniffer: bits in order of arrival, so MSB first lands at the top
  always @(posedge link.serial_clk) wire_word <= {wire_word[WORD_W-2:0], link.serial_data};
  always @(posedge link.latch_strobe) strobe_cnt++;
  // Pulses counted on the falling edge, away from the launching edge, so each one-cycle pulse is seen once
  always @(negedge clk_sys_i) begin
    if (latch_wr_o === 1'b1) wr_cnt++;
    if (f_wr === 1'b1) f_wr_cnt++;
  end

  // ==================== Compare and closing tasks
  task automatic check_val(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp, input string what);
    check_val({31'h0, got}, {31'h0, exp}, what);
  endtask
  task automatic end_sim();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==================== Host request; bad words must be refused untouched
  task automatic send_word(input logic [WORD_W-1:0] w, input bit bad);
    int n;
    int s0;
    int w0;
    s0 = strobe_cnt;
    w0 = wr_cnt;
    n = 0;
    cmd_word_i = w;
    cmd_valid_i = 1'b1;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    cmd_valid_i = 1'b0;
    if (bad) begin
      while (cmd_error_o !== 1'b1 && n < 3) begin
        @(negedge clk_sys_i);
        n++;
      end
      check_flag(cmd_error_o, 1'b1, "error pulse");
      if (cmd_error_o !== 1'b1) end_sim();
      repeat (20) @(negedge clk_sys_i);
      check_val(strobe_cnt - s0, 0, "strobes");
      check_val(wr_cnt - w0, 0, "refused writes");
    end else begin
      while (cmd_done_o !== 1'b1) begin
        @(negedge clk_sys_i);
        n++;
        if (n > 400) begin
          check_flag(1'b0, 1'b1, "done timeout");
          end_sim();
        end
      end
      check_flag(n == DONE_CYC, 1'b1, "done time");
      repeat (4) @(negedge clk_sys_i);
      check_val(wire_word, w, "wire bits");
      check_val(latch_data_o, w, "latch data");
      check_val(32'(latch_sel_o), 32'(w[SEL_W-1:0]), "latch select");
      check_val(strobe_cnt - s0, 1, "strobes");
      check_val(wr_cnt - w0, 1, "write pulses");
    end
    check_flag(cmd_ready_o, 1'b1, "ready");
  endtask

  // ==================== Bench driver for the second link, any bit count up to 64
  task automatic drive_bits(input logic [63:0] bits, input int n);
    int f0;
    f0 = f_wr_cnt;
    link_f.latch_strobe = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      link_f.serial_data = bits[i];
      repeat (4) @(negedge clk_sys_i);
      link_f.serial_clk = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      link_f.serial_clk = 1'b0;
    end
    repeat (4) @(negedge clk_sys_i);
    link_f.latch_strobe = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    link_f.latch_strobe = 1'b0;
    // Released data line shows the inverse, never a stale value
    link_f.serial_data = ~link_f.serial_data;
    repeat (8) @(negedge clk_sys_i);
    check_val(f_data, bits[31:0], "kept word");
    check_val(32'(f_sel), 32'(bits[2:0]), "kept select");
    check_val(f_wr_cnt - f0, 1, "kept write pulses");
  endtask

  // ==================== Main sequence
  initial begin
    logic [WORD_W-1:0] w;
    link_f.serial_clk = 1'b0;
    link_f.serial_data = 1'b0;
    link_f.latch_strobe = 1'b0;
    repeat (16) @(negedge clk_sys_i);
    check_flag(cmd_ready_o, 1'b1, "reset ready");
    check_flag(phase_valid_o, 1'b1, "reset valid");
    check_val(32'(phase_turn_o), 0, "reset turn");
    check_flag(link.latch_strobe, 1'b0, "reset strobe");
    reset_i = 1'b0;
    @(negedge clk_sys_i);
    for (int s = 0; s < 8; s++) begin
      if (s != 1) send_word({29'h1461d2f8 + 29'(s), 3'(s)}, 1'b0);
    end
    for (int k = 0; k < 6; k++) begin
      w = {5'h00, 12'(phs[k]), 12'(mods[k]), SEL_PHASE};
      send_word(w, 1'b0);
      check_flag(phase_valid_o, 1'b0, "valid drop");
      for (int t = 0; t < 60 && phase_valid_o !== 1'b1; t++) @(negedge clk_sys_i);
      check_flag(phase_valid_o, 1'b1, "valid back");
      if (phase_valid_o !== 1'b1) end_sim();
      check_val(32'(phase_turn_o), ((phs[k] * 65536) / mods[k]) % 65536, "turn");
    end
    send_word({17'h00003, 12'h000, SEL_PHASE}, 1'b1);
    send_word({17'h00003, 12'h001, SEL_PHASE}, 1'b1);
    drive_bits(64'h00000077_9ab3c5e6, 40);
    drive_bits(64'h00000000_5a3c_96c2, 32);
    end_sim();
  end
endmodule
`default_nettype wire
